//--- rtl/stats_counter_consts.vh
// constants for the statistics counter bank
`ifndef STATS_COUNTER_CONSTS_VH
`define STATS_COUNTER_CONSTS_VH

// register indices on the register port
`define REG_COUNTER_DATA_PORT 4'h0
`define REG_COUNTER_ACCESS_CONTROL 4'h1
`define REG_COUNTER_MANAGEMENT 4'h2
`define REG_TX_ROLLOVER_FLAGS 4'h3
`define REG_RX_ROLLOVER_FLAGS 4'h4
`define REG_TX_ROLLOVER_MASK 4'h5
`define REG_RX_ROLLOVER_MASK 4'h6
`define REG_HOST_INTERRUPT_STATUS 4'h7
`define REG_HOST_INTERRUPT_MASK 4'h8

// access control fields
`define CAC_ADDR_MSB 5
`define CAC_ADDR_LSB 0
`define CAC_WRITE_DIR_BIT 8
`define CAC_CLEAR_ON_READ_BIT 9
`define CAC_MUST_SET_BIT 10
`define CAC_RESET 32'h0000_0000

// management fields
`define MGMT_CLEAR_TX_BIT 0
`define MGMT_CLEAR_RX_BIT 1
`define MGMT_FREEZE_BIT 2

// host interrupt status: statistics summary bit
`define HIS_STATS_SUMMARY_BIT 0

// counter map
`define NUM_COUNTERS 40
`define NUM_TX_COUNTERS 15
`define NUM_RX_COUNTERS 25
`define TX_BYTES_COUNTER 14
`define RX_GOOD_BYTES_COUNTER 38
`define RX_BAD_BYTES_COUNTER 39

// frame size limits in bytes
`define LEN_64 16'h0040
`define LEN_127 16'h007F
`define LEN_255 16'h00FF
`define LEN_511 16'h01FF
`define LEN_1023 16'h03FF
`define LEN_MAX_PLAIN 16'h05EE
`define LEN_MAX_VLAN 16'h05F2
`define LEN_FIELD_LIMIT 16'h05DC
`define CONTROL_ETHERTYPE 16'h8808

// freeze hold time and minimum frame time at 100 Mbps, in ns
`define FREEZE_HOLD_NS 28000
`define MIN_FRAME_NS_100M 6720
// one slot per frame end per direction, both directions share the queue
`define EVENT_FIFO_DEPTH (2 * ((`FREEZE_HOLD_NS + `MIN_FRAME_NS_100M - 1) / `MIN_FRAME_NS_100M))

`endif

//--- rtl/stats_counter_bank.v
// statistics counter bank with indirect access, freeze queue and rollover flags
`include "stats_counter_consts.vh"

// What this block does
// - tx counters 0x00-0x0E, rx 0x0F-0x27
// - tx frames binned by collision count
// - each rx frame in one size bin
// - short errored fragments, long errored jabbers
// - length field over 1500, not 8808
// - tx bytes, good and bad rx bytes
// - direction bit: clear read, set write
// - clear-on-read zeroes counter in read direction
// - event during clear-on-read leaves one, or the frame's bytes in a byte counter
// - read direction: data port reads only
// - write direction: data port writes only
// - address steps after every accepted data access
// - event during host write stores value plus one, or plus the frame's bytes in a byte counter
// - freeze stops counters, events queue up
// - queue holds 28 us of minimum frames
// - unfreeze applies all queued events
// - full queue clears freeze by hardware
// - clear bits write-only, zero whole group
// - per-counter rollover flags in two registers
// - masked flags make summary, masked interrupt
module stats_counter_bank #(
  parameter FIFO_DEPTH = `EVENT_FIFO_DEPTH
)(
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  output reg [31:0] reg_rdata,
  input wire tx_frame_done,
  input wire [4:0] tx_collision_count,
  input wire tx_excess_collision,
  input wire tx_deferred,
  input wire [15:0] tx_byte_count,
  input wire [9:0] tx_misc_events,
  input wire rx_frame_done,
  input wire [15:0] rx_length,
  input wire rx_vlan,
  input wire rx_crc_error,
  input wire rx_align_error,
  input wire [15:0] rx_len_type,
  input wire [11:0] rx_misc_events,
  output wire host_irq
);

  function integer clog2;
    input integer value;
    integer v;
    begin
      v = value - 1;
      clog2 = 1;
      while (v > 1)
      begin
        v = v >> 1;
        clog2 = clog2 + 1;
      end
    end
  endfunction

  localparam PW = clog2(FIFO_DEPTH);
  localparam EW = 16 + `NUM_RX_COUNTERS + 16 + `NUM_TX_COUNTERS;
  localparam [31:0] CAC_RESET_VALUE = `CAC_RESET;

  reg [31:0] counts [0:`NUM_COUNTERS-1];
  reg [5:0] cac_addr;
  reg cac_write_dir;
  reg cac_clear_on_read;
  reg cac_must_set;
  reg freeze;
  reg [`NUM_COUNTERS-1:0] roll_flags;
  reg [`NUM_COUNTERS-1:0] roll_mask;
  reg his_mask;
  reg [EW-1:0] fifo_mem [0:FIFO_DEPTH-1];
  reg [PW-1:0] wr_ptr;
  reg [PW-1:0] rd_ptr;
  reg [PW:0] fifo_count;

  // event classification
  wire [15:0] rx_max_len = rx_vlan ? `LEN_MAX_VLAN : `LEN_MAX_PLAIN;
  wire rx_err = rx_crc_error | rx_align_error;
  wire rx_short = rx_length < `LEN_64;
  wire rx_long = rx_length > rx_max_len;
  wire rx_fragment = rx_frame_done & rx_short & rx_err;
  wire rx_jabber = rx_frame_done & rx_long & rx_err;
  wire [`NUM_TX_COUNTERS-1:0] tx_ev;
  wire [`NUM_RX_COUNTERS-1:0] rx_ev;

  assign tx_ev[0] = tx_frame_done & ~tx_excess_collision & ~tx_deferred
    & (tx_collision_count == 5'h00);
  assign tx_ev[1] = tx_frame_done & ~tx_excess_collision & (tx_collision_count == 5'h01);
  assign tx_ev[2] = tx_frame_done & ~tx_excess_collision & (tx_collision_count >= 5'h02)
    & (tx_collision_count <= 5'h0F);
  assign tx_ev[3] = tx_frame_done & tx_excess_collision;
  // other tx events map one to one
  assign tx_ev[13:4] = tx_misc_events;
  assign tx_ev[14] = tx_frame_done;

  assign rx_ev[0] = rx_frame_done & rx_short;
  assign rx_ev[1] = rx_frame_done & (rx_length == `LEN_64);
  assign rx_ev[2] = rx_frame_done & (rx_length > `LEN_64) & (rx_length <= `LEN_127);
  assign rx_ev[3] = rx_frame_done & (rx_length > `LEN_127) & (rx_length <= `LEN_255);
  assign rx_ev[4] = rx_frame_done & (rx_length > `LEN_255) & (rx_length <= `LEN_511);
  assign rx_ev[5] = rx_frame_done & (rx_length > `LEN_511) & (rx_length <= `LEN_1023);
  assign rx_ev[6] = rx_frame_done & (rx_length > `LEN_1023) & ~rx_long;
  assign rx_ev[7] = rx_frame_done & rx_long;
  assign rx_ev[9:8] = rx_misc_events[1:0];
  assign rx_ev[10] = rx_fragment;
  assign rx_ev[11] = rx_jabber;
  assign rx_ev[18:12] = rx_misc_events[8:2];
  assign rx_ev[19] = rx_frame_done & (rx_len_type > `LEN_FIELD_LIMIT)
    & (rx_len_type != `CONTROL_ETHERTYPE);
  assign rx_ev[22:20] = rx_misc_events[11:9];
  assign rx_ev[23] = rx_frame_done & ~rx_err;
  assign rx_ev[24] = rx_frame_done & rx_err & ~rx_fragment & ~rx_jabber;

  wire [EW-1:0] live_entry = {rx_length, rx_ev, tx_byte_count, tx_ev};
  wire live_any = (|tx_ev) | (|rx_ev);

  // event queue
  wire fifo_empty = (fifo_count == {(PW+1){1'b0}});
  // frozen or draining: events go through the queue to keep order
  wire push = live_any & (freeze | ~fifo_empty);
  // drain one entry per cycle once unfrozen
  wire pop = ~freeze & ~fifo_empty;
  wire [EW-1:0] applied = pop ? fifo_mem[rd_ptr] :
    ((~freeze & ~push) ? live_entry : {EW{1'b0}});
  wire [PW:0] next_fifo_count = fifo_count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

  function [PW-1:0] ptr_step;
    input [PW-1:0] ptr;
    begin
      if (ptr == FIFO_DEPTH[PW-1:0] - {{(PW-1){1'b0}}, 1'b1})
        ptr_step = {PW{1'b0}};
      else
        ptr_step = ptr + {{(PW-1){1'b0}}, 1'b1};
    end
  endfunction

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      wr_ptr <= {PW{1'b0}};
      rd_ptr <= {PW{1'b0}};
      fifo_count <= {(PW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= ptr_step(wr_ptr);
      if (pop)
        rd_ptr <= ptr_step(rd_ptr);
      fifo_count <= next_fifo_count;
    end
  end

  // depth sized for the freeze hold time
  always @(posedge clk)
  begin
    if (push)
      fifo_mem[wr_ptr] <= live_entry;
  end

  // register port decode
  wire sel_data = (reg_addr == `REG_COUNTER_DATA_PORT);
  wire sel_mgmt = reg_wr & (reg_addr == `REG_COUNTER_MANAGEMENT);
  wire addr_valid = cac_addr < `NUM_COUNTERS;
  wire data_rd_ok = reg_rd & sel_data & ~cac_write_dir;
  wire data_wr_ok = reg_wr & sel_data & cac_write_dir;
  wire clear_tx = sel_mgmt & reg_wdata[`MGMT_CLEAR_TX_BIT];
  wire clear_rx = sel_mgmt & reg_wdata[`MGMT_CLEAR_RX_BIT];
  wire [31:0] current_count = addr_valid ? counts[cac_addr] : 32'h0000_0000;

  // counter update
  wire [32*`NUM_COUNTERS-1:0] next_counts;
  wire [`NUM_COUNTERS-1:0] wrapped;

  genvar i;
  generate
    for (i = 0; i < `NUM_COUNTERS; i = i + 1)
    begin : g_counter
      localparam IS_TX = (i < `NUM_TX_COUNTERS);
      wire ev = IS_TX ? applied[i] : applied[16 + `NUM_TX_COUNTERS + i - `NUM_TX_COUNTERS];
      wire [15:0] bytes = IS_TX ? applied[`NUM_TX_COUNTERS +: 16] : applied[EW-16 +: 16];
      wire is_byte_ctr = (i == `TX_BYTES_COUNTER) || (i == `RX_GOOD_BYTES_COUNTER)
        || (i == `RX_BAD_BYTES_COUNTER);
      wire [15:0] amount = ev ? (is_byte_ctr ? bytes : 16'h0001) : 16'h0000;
      // group membership for the clear bits
      wire group_clear = IS_TX ? clear_tx : clear_rx;
      wire hit = (cac_addr == i);
      reg [31:0] base;
      always @*
      begin
        if (group_clear)
          base = 32'h0000_0000;
        // written value plus a coincident event
        else if (data_wr_ok & hit)
          base = reg_wdata;
        // clear after read, coincident event survives
        else if (data_rd_ok & hit & cac_clear_on_read)
          base = 32'h0000_0000;
        else
          base = counts[i];
      end
      wire [32:0] sum = {1'b0, base} + {17'h0_0000, amount};
      assign next_counts[32*i +: 32] = sum[31:0];
      assign wrapped[i] = sum[32];
    end
  endgenerate

  integer k;
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (k = 0; k < `NUM_COUNTERS; k = k + 1)
        counts[k] <= 32'h0000_0000;
    end
    else
    begin
      for (k = 0; k < `NUM_COUNTERS; k = k + 1)
        counts[k] <= next_counts[32*k +: 32];
    end
  end

  // control registers
  wire [`NUM_COUNTERS-1:0] flag_clear =
    (reg_wr & (reg_addr == `REG_TX_ROLLOVER_FLAGS)) ?
      {{`NUM_RX_COUNTERS{1'b0}}, reg_wdata[`NUM_TX_COUNTERS-1:0]} :
    (reg_wr & (reg_addr == `REG_RX_ROLLOVER_FLAGS)) ?
      {reg_wdata[`NUM_RX_COUNTERS-1:0], {`NUM_TX_COUNTERS{1'b0}}} :
      {`NUM_COUNTERS{1'b0}};

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cac_addr <= CAC_RESET_VALUE[`CAC_ADDR_MSB:`CAC_ADDR_LSB];
      cac_write_dir <= 1'b0;
      cac_clear_on_read <= 1'b0;
      cac_must_set <= 1'b0;
      freeze <= 1'b0;
      roll_flags <= {`NUM_COUNTERS{1'b0}};
      roll_mask <= {`NUM_COUNTERS{1'b0}};
      his_mask <= 1'b0;
    end
    else
    begin
      if (reg_wr & (reg_addr == `REG_COUNTER_ACCESS_CONTROL))
      begin
        // host supplies start address and must-set bit
        cac_addr <= reg_wdata[`CAC_ADDR_MSB:`CAC_ADDR_LSB];
        cac_write_dir <= reg_wdata[`CAC_WRITE_DIR_BIT];
        cac_clear_on_read <= reg_wdata[`CAC_CLEAR_ON_READ_BIT];
        cac_must_set <= reg_wdata[`CAC_MUST_SET_BIT];
      end
      // step after each accepted data access
      else if (data_rd_ok | data_wr_ok)
        cac_addr <= cac_addr + 6'h01;
      // queue filling ends the freeze; a host set is ignored then
      if (next_fifo_count == FIFO_DEPTH[PW:0])
        freeze <= 1'b0;
      // host sets or clears the freeze
      else if (sel_mgmt)
        freeze <= reg_wdata[`MGMT_FREEZE_BIT];
      // wrap sets flag, write-one clears, set wins
      roll_flags <= (roll_flags & ~flag_clear) | wrapped;
      if (reg_wr & (reg_addr == `REG_TX_ROLLOVER_MASK))
        roll_mask[`NUM_TX_COUNTERS-1:0] <= reg_wdata[`NUM_TX_COUNTERS-1:0];
      if (reg_wr & (reg_addr == `REG_RX_ROLLOVER_MASK))
        roll_mask[`NUM_COUNTERS-1:`NUM_TX_COUNTERS] <= reg_wdata[`NUM_RX_COUNTERS-1:0];
      if (reg_wr & (reg_addr == `REG_HOST_INTERRUPT_MASK))
        his_mask <= reg_wdata[`HIS_STATS_SUMMARY_BIT];
    end
  end

  // summary follows masked flags, irq gated by its own mask
  wire stats_summary = |(roll_flags & roll_mask);
  assign host_irq = stats_summary & his_mask;

  // read data
  reg [31:0] next_rdata;
  always @*
  begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      `REG_COUNTER_DATA_PORT:
        next_rdata = cac_write_dir ? 32'h0000_0000 : current_count;
      `REG_COUNTER_ACCESS_CONTROL:
      begin
        next_rdata[`CAC_ADDR_MSB:`CAC_ADDR_LSB] = cac_addr;
        next_rdata[`CAC_WRITE_DIR_BIT] = cac_write_dir;
        next_rdata[`CAC_CLEAR_ON_READ_BIT] = cac_clear_on_read;
        next_rdata[`CAC_MUST_SET_BIT] = cac_must_set;
      end
      `REG_COUNTER_MANAGEMENT:
        next_rdata[`MGMT_FREEZE_BIT] = freeze;
      `REG_TX_ROLLOVER_FLAGS:
        next_rdata[`NUM_TX_COUNTERS-1:0] = roll_flags[`NUM_TX_COUNTERS-1:0];
      `REG_RX_ROLLOVER_FLAGS:
        next_rdata[`NUM_RX_COUNTERS-1:0] = roll_flags[`NUM_COUNTERS-1:`NUM_TX_COUNTERS];
      `REG_TX_ROLLOVER_MASK:
        next_rdata[`NUM_TX_COUNTERS-1:0] = roll_mask[`NUM_TX_COUNTERS-1:0];
      `REG_RX_ROLLOVER_MASK:
        next_rdata[`NUM_RX_COUNTERS-1:0] = roll_mask[`NUM_COUNTERS-1:`NUM_TX_COUNTERS];
      `REG_HOST_INTERRUPT_STATUS:
        next_rdata[`HIS_STATS_SUMMARY_BIT] = stats_summary;
      `REG_HOST_INTERRUPT_MASK:
        next_rdata[`HIS_STATS_SUMMARY_BIT] = his_mask;
      default:
        next_rdata = 32'h0000_0000;
    endcase
  end

  // data is held until the next read so a slow host can sample late
  always @(posedge clk or posedge reset)
  begin
    if (reset)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

endmodule

//--- testbench/stats_counter_bank_monitor.sv
// checker on the register port and interrupt of the statistics counter bank
module stats_counter_monitor #(
  parameter FIFO_DEPTH = 10
)(
  input wire clk,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire host_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  reg mask_sh;
  reg dir_sh;
  // shadows rebuilt from port traffic, since the real mask and direction are internal
  always @(posedge clk or posedge reset)
    if (reset)
    begin
      mask_sh <= 1'b0;
      dir_sh <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h8)
        mask_sh <= reg_wdata[0];
      if (reg_addr == 4'h1)
        dir_sh <= reg_wdata[8];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_rdata_holds_idle: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_wrong_dir_zero: assert property (reg_rd && reg_addr == 4'h0 && dir_sh |=> reg_rdata == 32'h0)
    else $error("data port read in write direction returned data");
  a_dir_readback: assert property (reg_wr && reg_addr == 4'h1 ##2 reg_rd && reg_addr == 4'h1
    |=> (reg_rdata & 32'h0000_0700) == ($past(reg_wdata, 3) & 32'h0000_0700))
    else $error("access control mode bits not read back");
  a_clear_bits_zero: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[1:0] == 2'b00)
    else $error("group clear bits read as one");
  a_tx_flags_width: assert property (reg_rd && reg_addr == 4'h3 |=> reg_rdata[31:15] == 17'h0)
    else $error("tx rollover flags beyond bit 14");
  a_rx_flags_width: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata[31:25] == 7'h0)
    else $error("rx rollover flags beyond bit 24");
  a_irq_needs_mask: assert property (host_irq |-> mask_sh)
    else $error("interrupt raised with its mask clear");
  a_summary_is_irq: assert property (reg_rd && reg_addr == 4'h7 && mask_sh
    |=> reg_rdata[0] == $past(host_irq))
    else $error("summary bit disagrees with interrupt");
  a_irq_low_reset: assert property ($past(reset) |-> !host_irq)
    else $error("interrupt high right after reset");
endmodule

bind stats_counter_bank stats_counter_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_mon (
  .clk(clk),
  .reset(reset),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .host_irq(host_irq)
);

//--- testbench/host_port.sv
// host model driving the register port of the statistics counter bank
module host_port (
  input wire clk,
  input wire [31:0] reg_rdata,
  output logic [3:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [31:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 4'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 32'h0;
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines must not keep looking like the last request
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    acc(1'b0, a, 32'h0, q);
  endtask
  task automatic cac(input logic [5:0] a, input logic dir, input logic cor);
    wr(4'h1, {21'h0, 1'b1, cor, dir, 2'b00, a});
  endtask
endmodule

//--- testbench/tb.sv
// self-checking bench for the statistics counter bank
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, reg_wr, reg_rd, tx_frame_done, tx_excess_collision, tx_deferred;
  logic rx_frame_done, rx_vlan, rx_crc_error, rx_align_error;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, got, sum;
  logic [4:0] tx_collision_count;
  logic [15:0] tx_byte_count, rx_length, rx_len_type;
  logic [9:0] tx_misc_events;
  logic [11:0] rx_misc_events;
  wire host_irq;
  int error_cnt, cmp_count, cyc;
  int exp_tx [4] = '{1, 1, 2, 1};
  int exp_rx [8] = '{2, 3, 2, 1, 1, 1, 3, 3};
  int rlen [11] = '{63, 64, 65, 128, 256, 512, 1024, 1518, 1519, 1522, 1523};
  stats_counter_bank #(.FIFO_DEPTH(3)) i_stats_counter_bank (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .tx_frame_done(tx_frame_done), .tx_collision_count(tx_collision_count),
    .tx_excess_collision(tx_excess_collision), .tx_deferred(tx_deferred),
    .tx_byte_count(tx_byte_count), .tx_misc_events(tx_misc_events), .rx_frame_done(rx_frame_done),
    .rx_length(rx_length), .rx_vlan(rx_vlan), .rx_crc_error(rx_crc_error),
    .rx_align_error(rx_align_error), .rx_len_type(rx_len_type), .rx_misc_events(rx_misc_events),
    .host_irq(host_irq));
  host_port i_host_port (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    i_host_port.cac(a, 1'b0, 1'b0);
    i_host_port.rd(4'h0, got);
    chk(got, e);
  endtask
  task automatic ev(input logic t, input logic r, input logic [9:0] m);
    @(posedge clk);
    #1;
    tx_frame_done = t;
    rx_frame_done = r;
    tx_misc_events = m;
    @(posedge clk);
    #1;
    tx_frame_done = 1'b0;
    rx_frame_done = 1'b0;
    tx_misc_events = 10'h000;
  endtask
  task automatic txf(input logic [4:0] c, input logic x, input logic d);
    tx_collision_count = c;
    tx_excess_collision = x;
    tx_deferred = d;
    ev(1'b1, 1'b0, 10'h000);
  endtask
  task automatic rxf(input int l, input logic v, input logic [1:0] e, input logic [15:0] lt);
    rx_length = l[15:0];
    rx_vlan = v;
    {rx_align_error, rx_crc_error} = e;
    rx_len_type = lt;
    ev(1'b0, 1'b1, 10'h000);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: timeout", $time);
      report_and_stop();
    end
  end
  initial
  begin
    {reset, tx_frame_done, rx_frame_done, tx_excess_collision, tx_deferred} = 5'h1F;
    {tx_frame_done, rx_frame_done, tx_excess_collision, tx_deferred, rx_vlan} = 5'h0;
    {rx_crc_error, rx_align_error, tx_collision_count, tx_misc_events} = 17'h0;
    {rx_length, rx_len_type, rx_misc_events} = 44'h0;
    tx_byte_count = 16'h0100;
    repeat (8) @(posedge clk);
    #1;
    reset = 1'b0;
    i_host_port.cac(6'h10, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++)
      i_host_port.wr(4'h0, 32'h1234_0000 + k);
    i_host_port.rd(4'h0, got);
    chk(got, 32'h0);
    i_host_port.cac(6'h10, 1'b0, 1'b1);
    i_host_port.rd(4'h1, got);
    chk(got, 32'h0000_0610);
    for (int k = 0; k < 3; k++)
    begin
      i_host_port.rd(4'h0, got);
      chk(got, 32'h1234_0000 + k);
    end
    rdc(6'h10, 32'h0);
    i_host_port.cac(6'h09, 1'b1, 1'b0);
    fork
      i_host_port.wr(4'h0, 32'h0000_0050);
      ev(1'b0, 1'b0, 10'h020);
    join
    rdc(6'h09, 32'h0000_0051);
    i_host_port.cac(6'h09, 1'b0, 1'b1);
    fork
      i_host_port.rd(4'h0, got);
      ev(1'b0, 1'b0, 10'h020);
    join
    chk(got, 32'h0000_0051);
    rdc(6'h09, 32'h1);
    $display("test access done");
    txf(5'd0, 1'b0, 1'b0);
    txf(5'd0, 1'b0, 1'b1);
    txf(5'd1, 1'b0, 1'b0);
    txf(5'd2, 1'b0, 1'b0);
    txf(5'd15, 1'b0, 1'b0);
    txf(5'd16, 1'b1, 1'b0);
    i_host_port.cac(6'h00, 1'b0, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      i_host_port.rd(4'h0, got);
      chk(got, exp_tx[k]);
    end
    rdc(6'h0E, 32'h0000_0600);
    $display("test tx done");
    sum = 32'd128;
    for (int k = 0; k < 11; k++)
    begin
      rxf(rlen[k], k > 8, 2'b00, 16'h002E);
      sum = sum + rlen[k];
    end
    rxf(64, 1'b0, 2'b00, 16'h8808);
    rxf(64, 1'b0, 2'b00, 16'h05DD);
    rxf(40, 1'b0, 2'b01, 16'h0028);
    rxf(2000, 1'b0, 2'b10, 16'h002E);
    rxf(100, 1'b0, 2'b01, 16'h0064);
    i_host_port.cac(6'h0F, 1'b0, 1'b0);
    for (int k = 0; k < 8; k++)
    begin
      i_host_port.rd(4'h0, got);
      chk(got, exp_rx[k]);
    end
    rdc(6'h19, 32'h1);
    rdc(6'h1A, 32'h1);
    rdc(6'h22, 32'h1);
    rdc(6'h26, sum);
    rdc(6'h27, 32'h0000_0064);
    $display("test rx done");
    i_host_port.wr(4'h2, 32'h0000_0004);
    repeat (2) ev(1'b0, 1'b0, 10'h001);
    rdc(6'h04, 32'h0);
    i_host_port.wr(4'h2, 32'h0000_0000);
    rdc(6'h04, 32'h2);
    i_host_port.wr(4'h2, 32'h0000_0004);
    repeat (3) ev(1'b0, 1'b0, 10'h001);
    i_host_port.rd(4'h2, got);
    chk(got, 32'h0);
    rdc(6'h04, 32'h5);
    i_host_port.wr(4'h2, 32'h0000_0001);
    rdc(6'h04, 32'h0);
    rdc(6'h26, sum);
    i_host_port.wr(4'h2, 32'h0000_0002);
    rdc(6'h26, 32'h0);
    $display("test management done");
    i_host_port.cac(6'h05, 1'b1, 1'b0);
    i_host_port.wr(4'h0, 32'hFFFF_FFFF);
    ev(1'b0, 1'b0, 10'h002);
    i_host_port.rd(4'h3, got);
    chk(got, 32'h0000_0020);
    rdc(6'h05, 32'h0);
    i_host_port.wr(4'h8, 32'h0000_0001);
    chk({31'h0, host_irq}, 32'h0);
    i_host_port.wr(4'h5, 32'h0000_0020);
    chk({31'h0, host_irq}, 32'h1);
    i_host_port.rd(4'h7, got);
    chk(got, 32'h1);
    i_host_port.wr(4'h3, 32'h0000_0020);
    chk({31'h0, host_irq}, 32'h0);
    i_host_port.cac(6'h17, 1'b1, 1'b0);
    i_host_port.wr(4'h0, 32'hFFFF_FFFF);
    @(posedge clk);
    #1;
    rx_misc_events = 12'h001;
    @(posedge clk);
    #1;
    rx_misc_events = 12'h000;
    i_host_port.rd(4'h4, got);
    chk(got, 32'h0000_0100);
    i_host_port.wr(4'h4, 32'h0000_0100);
    i_host_port.rd(4'h4, got);
    chk(got, 32'h0);
    i_host_port.rd(4'hC, got);
    chk(got, 32'h0);
    $display("test rollover done");
    report_and_stop();
  end
endmodule
